// [logic/jbstap_consts.svh]
// Constants of the boundary-scan test access port
`ifndef JBSTAP_CONSTS_SVH
`define JBSTAP_CONSTS_SVH
`define JBS_IR_W 3
`define JBS_IR_EXTEST 3'h0
`define JBS_IR_SAMPLE 3'h4
`define JBS_IR_IDCODE 3'h6
`define JBS_IR_BYPASS 3'h7
`define JBS_IR_CAPTURE 3'h1
`define JBS_IR_RESET 3'h6
`define JBS_BSC_LEN 98
`define JBS_ID_LEN 32
`define JBS_LP_PINS 8
`define JBS_DIR_CELL 16
`define JBS_OTHER_BASE 17
`define JBS_OTHER_W 81
`define JBS_DIR_RESET 1'h1
`define JBS_ID_FIXED 1'h1
`define JBS_ID_PROD_W 11
`define JBS_ID_PART_W 16
`define JBS_ID_REV_W 4
`define JBS_PASS_CAPTURE 1'h0
`endif

// [logic/jbstap_pkg.sv]
// Types of the boundary-scan test access port
`include "jbstap_consts.svh"
package jbstap_pkg;
    typedef enum logic [3:0] {
        TAP_RESET = 4'h0,
        TAP_IDLE = 4'h1,
        TAP_SEL_DR = 4'h2,
        TAP_CAP_DR = 4'h3,
        TAP_SHIFT_DR = 4'h4,
        TAP_EXIT1_DR = 4'h5,
        TAP_PAUSE_DR = 4'h6,
        TAP_EXIT2_DR = 4'h7,
        TAP_UPD_DR = 4'h8,
        TAP_SEL_IR = 4'h9,
        TAP_CAP_IR = 4'ha,
        TAP_SHIFT_IR = 4'hb,
        TAP_EXIT1_IR = 4'hc,
        TAP_PAUSE_IR = 4'hd,
        TAP_EXIT2_IR = 4'he,
        TAP_UPD_IR = 4'hf
    } jbstap_state_e;
    typedef enum logic [1:0] {
        SEL_BOUNDARY = 2'h0,
        SEL_ID = 2'h1,
        SEL_PASS = 2'h2
    } jbstap_sel_e;
    typedef struct packed {
        logic [`JBS_LP_PINS-1:0] out;
        logic oe;
    } jbstap_lp_s;
endpackage

// [logic/jbstap_sync.sv]
// Two-flop level synchroniser of parameterised width
`timescale 1ns/1ps
module jbstap_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Level in and out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// [logic/jbstap_top.sv]
// Boundary-scan test access port with boundary, identity and passthrough chains
// How it works
// - The tap state machine follows tms on tck, and the selected chain shifts from tdi to tdo.
// - The instruction register is three bits wide and is loaded least significant bit first.
// - Code 000 places the boundary chain between tdi and tdo for interconnect testing.
// - Under external test the pin inputs are captured in Capture-DR and shifted in Shift-DR.
// - Under external test the pads are driven from the pattern latched at Update-DR.
// - Code 100 places the boundary chain in the path and leaves core to pin wiring untouched.
// - Under sample/preload the loop port outputs, direction and all pin inputs are captured in Capture-DR for shifting.
// - Code 110 places the identity chain in the path so its value shifts out in Shift-DR.
// - Code 111 passes tdi to tdo with exactly one tck period of delay.
// - The identity chain is 32 bits and leaves tdo least significant bit first.
// - The identity value is a one in bit 0, producer in 1-11, part in 12-27, revision in 28-31.
// - Cells 0 to 15 pair each loop port pin as output cell then sampled input cell.
// - The one-bit passthrough stage forms the short path that skips the boundary chain.
// - The boundary chain is 98 cells and is reached only by external test or sample/preload.
// - Cell 16 sets loop port direction, zero drives the pins and one floats them.
`timescale 1ns/1ps
`include "jbstap_consts.svh"
module jbstap_top
    import jbstap_pkg::*;
#(
    parameter logic [`JBS_ID_PROD_W-1:0] PRODUCER_ID = 11'h155, // Arbitrary value
    parameter logic [`JBS_ID_PART_W-1:0] PART_ID = 16'h1234, // Arbitrary value
    parameter logic [`JBS_ID_REV_W-1:0] REVISION_ID = 4'h1 // Arbitrary value
) (
    // System clock domain
    input wire logic clk,
    input wire logic sys_rst,
    output logic core_isolated,
    // Test port, link clock domain
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // Loop port pins, core side and pad side
    input wire jbstap_lp_s core_lp,
    input wire logic [`JBS_LP_PINS-1:0] lp_pad_in,
    output logic [`JBS_LP_PINS-1:0] lp_pad_out,
    output logic [`JBS_LP_PINS-1:0] lp_pad_oe,
    // Remaining boundary pins
    input wire logic [`JBS_OTHER_W-1:0] core_other_out,
    input wire logic [`JBS_OTHER_W-1:0] other_pad_in,
    output logic [`JBS_OTHER_W-1:0] other_pad_out
);
    localparam int NP = `JBS_LP_PINS;
    localparam int BL = `JBS_BSC_LEN;
    localparam int OW = `JBS_OTHER_W;
    localparam int SW = NP + 1 + NP + OW;
    localparam logic [`JBS_ID_LEN-1:0] ID_VALUE =
        {REVISION_ID, PART_ID, PRODUCER_ID, `JBS_ID_FIXED};

    jbstap_state_e state_reg;
    jbstap_state_e state_next;
    jbstap_sel_e dr_sel;
    logic [`JBS_IR_W-1:0] ir_shift_reg;
    logic [`JBS_IR_W-1:0] ir_reg;
    logic [`JBS_ID_LEN-1:0] id_shift_reg;
    logic pass_reg;
    logic [BL-1:0] bsc_shift_reg;
    logic [BL-1:0] bsc_upd_reg;
    logic [BL-1:0] bsc_capture;
    logic [SW-1:0] raw_in;
    logic [SW-1:0] synced_in;
    jbstap_lp_s core_lp_s;
    logic [NP-1:0] lp_in_s;
    logic [OW-1:0] other_in_s;
    logic extest;
    logic serial_out;
    logic shifting;

    // Pins and core levels reach the tck domain through two flops
    assign raw_in = {other_pad_in, lp_pad_in, core_lp};
    jbstap_sync #(.W(SW)) u_pin_sync (
        .clk(tck),
        .rst(sys_rst),
        .d(raw_in),
        .q(synced_in)
    );
    assign core_lp_s = synced_in[NP:0];
    assign lp_in_s = synced_in[2*NP:NP+1];
    assign other_in_s = synced_in[SW-1:2*NP+1];

    // Core learns it is isolated through a level crossing
    jbstap_sync #(.W(1)) u_iso_sync (
        .clk(clk),
        .rst(sys_rst),
        .d(extest),
        .q(core_isolated)
    );

    always_comb begin
        case (state_reg)
            TAP_RESET: state_next = tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: state_next = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: state_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: state_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: state_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: state_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: state_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: state_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: state_next = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: state_next = tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: state_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: state_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: state_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: state_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: state_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: state_next = tms ? TAP_SEL_DR : TAP_IDLE;
            default: state_next = TAP_RESET;
        endcase
    end

    always_ff @(posedge tck or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= TAP_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // three-bit instruction, shifted in lsb first
    always_ff @(posedge tck or posedge sys_rst) begin
        if (sys_rst) begin
            ir_shift_reg <= `JBS_IR_CAPTURE;
            ir_reg <= `JBS_IR_RESET;
        end else begin
            case (state_reg)
                TAP_RESET: ir_reg <= `JBS_IR_RESET;
                TAP_CAP_IR: ir_shift_reg <= `JBS_IR_CAPTURE;
                TAP_SHIFT_IR: ir_shift_reg <= {tdi, ir_shift_reg[`JBS_IR_W-1:1]};
                TAP_UPD_IR: ir_reg <= ir_shift_reg;
                default: ir_reg <= ir_reg;
            endcase
        end
    end

    // instruction decode, unused codes fall to the passthrough
    always_comb begin
        case (ir_reg)
            `JBS_IR_EXTEST: dr_sel = SEL_BOUNDARY;
            `JBS_IR_SAMPLE: dr_sel = SEL_BOUNDARY;
            `JBS_IR_IDCODE: dr_sel = SEL_ID;
            `JBS_IR_BYPASS: dr_sel = SEL_PASS;
            default: dr_sel = SEL_PASS;
        endcase
    end
    assign extest = (ir_reg == `JBS_IR_EXTEST);

    always_ff @(posedge tck or posedge sys_rst) begin
        if (sys_rst) begin
            id_shift_reg <= '0;
        end else if (dr_sel == SEL_ID && state_reg == TAP_CAP_DR) begin
            id_shift_reg <= ID_VALUE;
        end else if (dr_sel == SEL_ID && state_reg == TAP_SHIFT_DR) begin
            id_shift_reg <= {tdi, id_shift_reg[`JBS_ID_LEN-1:1]};
        end
    end

    always_ff @(posedge tck or posedge sys_rst) begin
        if (sys_rst) begin
            pass_reg <= `JBS_PASS_CAPTURE;
        end else if (dr_sel == SEL_PASS && state_reg == TAP_CAP_DR) begin
            pass_reg <= `JBS_PASS_CAPTURE;
        end else if (dr_sel == SEL_PASS && state_reg == TAP_SHIFT_DR) begin
            pass_reg <= tdi;
        end
    end

    // paired loop port cells, output value then sampled input
    // under external test the driven value is the latched pattern
    // under sample/preload the core's own outputs are seen
    always_comb begin
        bsc_capture = '0;
        for (int i = 0; i < NP; i++) begin
            bsc_capture[2*i] = extest ? bsc_upd_reg[2*i] : core_lp_s.out[i];
            bsc_capture[2*i+1] = lp_in_s[i];
        end
        // direction cell captures the float state
        bsc_capture[`JBS_DIR_CELL] = extest ? bsc_upd_reg[`JBS_DIR_CELL] : ~core_lp_s.oe;
        bsc_capture[BL-1:`JBS_OTHER_BASE] = other_in_s;
    end

    // boundary chain reached only through its two instructions
    always_ff @(posedge tck or posedge sys_rst) begin
        if (sys_rst) begin
            bsc_shift_reg <= '0;
        end else if (dr_sel == SEL_BOUNDARY && state_reg == TAP_CAP_DR) begin
            bsc_shift_reg <= bsc_capture;
        end else if (dr_sel == SEL_BOUNDARY && state_reg == TAP_SHIFT_DR) begin
            bsc_shift_reg <= {tdi, bsc_shift_reg[BL-1:1]};
        end
    end

    // pattern latched at Update-DR; tap reset loads the float state into the direction cell
    always_ff @(posedge tck or posedge sys_rst) begin
        if (sys_rst) begin
            bsc_upd_reg <= '0;
            bsc_upd_reg[`JBS_DIR_CELL] <= `JBS_DIR_RESET;
        end else if (state_reg == TAP_RESET) begin
            bsc_upd_reg <= '0;
            bsc_upd_reg[`JBS_DIR_CELL] <= `JBS_DIR_RESET;
        end else if (dr_sel == SEL_BOUNDARY && state_reg == TAP_UPD_DR) begin
            bsc_upd_reg <= bsc_shift_reg;
        end
    end

    // pads follow the core unless external test is current
    always_comb begin
        for (int i = 0; i < NP; i++) begin
            lp_pad_out[i] = extest ? bsc_upd_reg[2*i] : core_lp.out[i];
            // zero in the direction cell drives the pins
            lp_pad_oe[i] = extest ? ~bsc_upd_reg[`JBS_DIR_CELL] : core_lp.oe;
        end
        other_pad_out = extest ? bsc_upd_reg[BL-1:`JBS_OTHER_BASE] : core_other_out;
    end

    // serial output of the selected chain
    always_comb begin
        if (state_reg == TAP_SHIFT_IR) begin
            serial_out = ir_shift_reg[0];
        end else begin
            case (dr_sel)
                SEL_BOUNDARY: serial_out = bsc_shift_reg[0];
                SEL_ID: serial_out = id_shift_reg[0];
                SEL_PASS: serial_out = pass_reg;
                default: serial_out = pass_reg;
            endcase
        end
    end
    assign shifting = (state_reg == TAP_SHIFT_DR) || (state_reg == TAP_SHIFT_IR);

    // tdo moves on the falling edge so the far end has half a period
    always_ff @(negedge tck or posedge sys_rst) begin
        if (sys_rst) begin
            tdo <= 1'h0;
            tdo_oe <= 1'h0;
        end else begin
            tdo <= serial_out;
            tdo_oe <= shifting;
        end
    end

    chk_tms_reset: assert property (@(posedge tck) disable iff (sys_rst)
        tms [*5] |=> state_reg == TAP_RESET)
        else $error("five tms highs did not reach reset");
    chk_ir_lsb_in: assert property (@(posedge tck) disable iff (sys_rst)
        state_reg == TAP_SHIFT_IR ##1 state_reg == TAP_SHIFT_IR |->
        ir_shift_reg[2] == $past(tdi) && ir_shift_reg[1:0] == $past(ir_shift_reg[2:1]))
        else $error("instruction not shifted lsb first");
    chk_extest_pads: assert property (@(posedge tck) disable iff (sys_rst)
        ir_reg == `JBS_IR_EXTEST |-> lp_pad_oe[3] == ~bsc_upd_reg[16] &&
        lp_pad_out[3] == bsc_upd_reg[6] && other_pad_out[0] == bsc_upd_reg[17])
        else $error("pads not driven from boundary pattern");
    chk_sample_intact: assert property (@(posedge tck) disable iff (sys_rst)
        ir_reg == `JBS_IR_SAMPLE |-> lp_pad_out == core_lp.out &&
        other_pad_out == core_other_out)
        else $error("sample disturbed the core path");
    chk_pin_capture: assert property (@(posedge tck) disable iff (sys_rst)
        state_reg == TAP_CAP_DR && dr_sel == SEL_BOUNDARY |=>
        bsc_shift_reg[1] == $past(lp_in_s[0]) && bsc_shift_reg[15] == $past(lp_in_s[7]))
        else $error("pin inputs not captured");
    chk_id_value: assert property (@(posedge tck) disable iff (sys_rst)
        state_reg == TAP_CAP_DR && dr_sel == SEL_ID |=>
        id_shift_reg == ID_VALUE && id_shift_reg[0] == 1'h1)
        else $error("identity value wrong at capture");
    chk_pass_delay: assert property (@(posedge tck) disable iff (sys_rst)
        state_reg == TAP_SHIFT_DR && dr_sel == SEL_PASS ##1 dr_sel == SEL_PASS |->
        serial_out == $past(tdi))
        else $error("passthrough delay not one tck");
    chk_odd_bypass: assert property (@(posedge tck) disable iff (sys_rst)
        ir_reg != `JBS_IR_EXTEST && ir_reg != `JBS_IR_SAMPLE &&
        ir_reg != `JBS_IR_IDCODE |-> dr_sel == SEL_PASS)
        else $error("unassigned code not bypassed");
    chk_update_hold: assert property (@(posedge tck) disable iff (sys_rst)
        state_reg != TAP_UPD_DR && state_reg != TAP_RESET |=> $stable(bsc_upd_reg))
        else $error("boundary pattern changed outside update");
    chk_tdo_edge: assert property (@(posedge tck) disable iff (sys_rst)
        shifting ##1 shifting |-> tdo == serial_out && tdo_oe)
        else $error("tdo not taken from the falling edge");
endmodule

// [sim/jbstap_ctrl_model.sv]
// Behavioural scan controller that drives the test port
`timescale 1ns/1ps
`include "jbstap_consts.svh"
module jbstap_ctrl_model (
    // Test port, controller side
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One tck period; tck rests low between frames, tdo read before the rise
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #80;
        o = tdo;
        tck = 1'b1;
        #80;
        tck = 1'b0;
    endtask

    // Five tms-high periods always reach reset, then park in Idle
    task automatic tap_reset();
        logic o;
        for (int i = 0; i < 5; i++) begin
            step(1'b1, 1'b0, o);
        end
        step(1'b0, 1'b0, o);
    endtask

    task automatic scan_ir(input logic [`JBS_IR_W-1:0] code, output logic [`JBS_IR_W-1:0] cap);
        logic o;
        step(1'b1, 1'b0, o);
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < `JBS_IR_W; i++) begin
            step(i == `JBS_IR_W - 1, code[i], cap[i]);
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask

    // Shift n bits through the selected chain, then update and idle
    task automatic scan_dr(input int n, input logic [97:0] din, output logic [97:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i]);
        end
        step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
    endtask
endmodule

// [sim/test_jbstap_top.sv]
// Self-checking bench of the boundary-scan test access port
`timescale 1ns/1ps
`include "jbstap_consts.svh"
module test_jbstap_top;
    import jbstap_pkg::*;
    localparam logic [10:0] PROD = 11'h2a3; // Arbitrary value
    localparam logic [15:0] PART = 16'h5c01; // Arbitrary value
    localparam logic [3:0] REV = 4'h9; // Arbitrary value
    localparam logic [80:0] OTH_A = {1'b1, 80'hdead_beef_0123_4567_89ab};
    localparam logic [80:0] OTH_B = {1'b0, 80'h1357_9bdf_2468_ace0_f00f};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic core_isolated, tck, tms, tdi, tdo, tdo_oe;
    jbstap_lp_s core_lp = '{out: 8'h00, oe: 1'b0};
    logic [7:0] lp_pad_in = 8'h00;
    logic [7:0] lp_pad_out, lp_pad_oe;
    logic [80:0] core_other_out = 81'h0;
    logic [80:0] other_pad_in = 81'h0;
    logic [80:0] other_pad_out;
    int fails = 0;
    int check_count = 0;
    logic [2:0] ir_cap;
    logic [97:0] dout;

    always #12.5 clk = ~clk;

    jbstap_top #(.PRODUCER_ID(PROD), .PART_ID(PART), .REVISION_ID(REV)) jbstap_top_inst (
        .clk(clk), .sys_rst(sys_rst), .core_isolated(core_isolated),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .core_lp(core_lp), .lp_pad_in(lp_pad_in), .lp_pad_out(lp_pad_out),
        .lp_pad_oe(lp_pad_oe), .core_other_out(core_other_out),
        .other_pad_in(other_pad_in), .other_pad_out(other_pad_out)
    );

    jbstap_ctrl_model jbstap_ctrl_model_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [97:0] got, input logic [97:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: %s", $time, what);
            fails++;
        end
    endtask

    // Isolation flag crosses into clk, so allow a bounded settling time
    task automatic wait_iso(input logic v);
        int n;
        n = 0;
        while (core_isolated !== v && n < 40) begin
            @(negedge clk);
            n++;
        end
        check_count++;
        if (core_isolated !== v) begin
            $display("unexpected at %0t: core isolation flag", $time);
            fails++;
            end_of_test();
        end
    endtask

    function automatic logic [97:0] cap_exp(input logic [7:0] ev, input logic [7:0] od,
            input logic c16, input logic [80:0] oth);
        logic [97:0] r;
        r = {oth, c16, 16'h0};
        for (int i = 0; i < 8; i++) begin
            r[2*i] = ev[i];
            r[2*i+1] = od[i];
        end
        return r;
    endfunction

    task automatic t_idcode();
        logic [31:0] id;
        id = {REV, PART, PROD, 1'b1};
        jbstap_ctrl_model_inst.scan_dr(32, 98'h0, dout);
        chk(dout[31:0], id, "identity after reset");
        jbstap_ctrl_model_inst.scan_ir(3'h6, ir_cap);
        chk(ir_cap, 3'h1, "instruction capture");
        jbstap_ctrl_model_inst.scan_dr(32, 98'h0, dout);
        chk(dout[31:0], id, "identity selected");
        chk(tdo_oe, 1'b0, "tdo enable outside shift");
        $display("test identity done");
    endtask

    task automatic t_bypass();
        logic [2:0] codes [5];
        codes = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h5};
        for (int k = 0; k < 5; k++) begin
            jbstap_ctrl_model_inst.scan_ir(codes[k], ir_cap);
            jbstap_ctrl_model_inst.scan_dr(9, 98'h1b2, dout);
            chk(dout[8:0], 9'h164, "one stage delay");
        end
        $display("test passthrough done");
    endtask

    task automatic t_sample();
        @(negedge clk);
        core_lp = '{out: 8'h5a, oe: 1'b1};
        lp_pad_in = 8'h3c;
        core_other_out = OTH_A;
        other_pad_in = OTH_B;
        jbstap_ctrl_model_inst.scan_ir(3'h4, ir_cap);
        jbstap_ctrl_model_inst.scan_dr(98, {OTH_A, 1'b1, 16'h0}, dout);
        chk(dout, cap_exp(8'h5a, 8'h3c, 1'b0, OTH_B), "sample capture");
        chk(lp_pad_out, 8'h5a, "loop pins follow core");
        chk(lp_pad_oe, 8'hff, "loop enables follow core");
        chk(other_pad_out, OTH_A, "other pins follow core");
        chk(core_isolated, 1'b0, "core not isolated");
        $display("test sample done");
    endtask

    task automatic t_extest();
        @(negedge clk);
        lp_pad_in = 8'hc3;
        other_pad_in = OTH_A;
        jbstap_ctrl_model_inst.scan_ir(3'h0, ir_cap);
        wait_iso(1'b1);
        jbstap_ctrl_model_inst.scan_dr(98, cap_exp(8'ha5, 8'h00, 1'b0, OTH_B), dout);
        chk(lp_pad_out, 8'ha5, "loop pins from chain");
        chk(lp_pad_oe, 8'hff, "direction cell drives");
        chk(other_pad_out, OTH_B, "other pins from chain");
        jbstap_ctrl_model_inst.scan_dr(98, cap_exp(8'h00, 8'h00, 1'b1, OTH_A), dout);
        chk(dout, cap_exp(8'ha5, 8'hc3, 1'b0, OTH_A), "extest capture");
        chk(lp_pad_oe, 8'h00, "direction cell floats");
        chk(other_pad_out, OTH_A, "second pattern applied");
        jbstap_ctrl_model_inst.tap_reset();
        wait_iso(1'b0);
        chk(lp_pad_out, 8'h5a, "core path after reset");
        $display("test extest done");
    endtask

    initial begin
        fork
            repeat (16) @(negedge clk);
            jbstap_ctrl_model_inst.step(1'b1, 1'b0, ir_cap[0]);
        join
        sys_rst = 1'b0;
        @(negedge clk);
        jbstap_ctrl_model_inst.tap_reset();
        t_idcode();
        t_bypass();
        t_sample();
        t_extest();
        end_of_test();
    end
endmodule
